/* src/swc_standby_ctrl.sv */
`timescale 1ns/10ps
`include "swc_map.svh"
// Summary of operation
// - Watch timer overflow raises the watch test signal and sets the watch test flag.
// - The watch test flag releases standby only while its mask bit is clear.
// - Watch test wake resumes execution with no vectored branch.
// - Reset clears the request flag register to all zeros.
// - Reset sets the mask flag register to all ones.
// - Request and mask registers accept single-bit and whole-byte writes.
// - Halt instruction gates the CPU clock while oscillators keep running.
// - Stop instruction halts the main oscillator and everything clocked from it.
// - Sleep modes leave registers, flags, memory and port state untouched.
// - Stop is taken only on main clock; halt works from either clock.
// - Settle select register takes whole-byte writes only.
// - Reset loads settle select with four, giving a 2^17 period wait.
// - Codes zero to four select 2^12, 2^14, 2^15, 2^16, 2^17 periods.
// - The settle wait starts counting only once the oscillator runs.
// - Halt on main clock without subclock runs watch timer only on divided main source.
// - Halt on subclock, main stopped: 8-bit timers need external inputs; 16-bit timer, converter and buzzer stop.
// - Halt on subclock, main stopped: clock output runs only from subclock.
// - Halt on subclock, main stopped: serial runs only with external clock.
// - Unmasked watch test during halt resumes at the next instruction.
// - Unmasked watch test during stop waits the settle time, then resumes.
// - Reset during stop starts reset processing only after the settle wait.
module swc_standby_ctrl
#(
  parameter int unsigned WAIT_C0 = `SWC_WAIT_C0,
  parameter int unsigned WAIT_C1 = `SWC_WAIT_C1,
  parameter int unsigned WAIT_C2 = `SWC_WAIT_C2,
  parameter int unsigned WAIT_C3 = `SWC_WAIT_C3,
  parameter int unsigned WAIT_C4 = `SWC_WAIT_C4
)
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [15:0]           cpu_addr,
  input  wire swc_pkg::swc_byte_type cpu_wdata,
  input  wire logic                  cpu_wr_byte,
  input  wire logic                  cpu_wr_bit,
  input  wire logic [2:0]            cpu_bit_sel,
  input  wire logic                  cpu_bit_val,
  input  wire logic                  cpu_rd,
  input  wire logic                  halt_cmd,
  input  wire logic                  stop_cmd,
  input  wire logic                  cpu_on_subclk,
  input  wire logic                  sub_osc_present,
  input  wire logic                  main_osc_halted,
  input  wire logic                  main_osc_ready,
  input  wire logic                  watch_overflow,
  input  wire logic                  wt_src_main_div,
  input  wire logic                  wt_src_sub,
  input  wire logic                  tmr8_ext_sel,
  input  wire logic                  clkout_sub_sel,
  input  wire logic                  serial_ext_sel,
  output swc_pkg::swc_byte_type      cpu_rdata,
  output logic                       cpu_clk_en,
  output logic                       main_osc_en,
  output logic                       resume_next,
  output logic                       reset_hold,
  output logic                       watch_test_signal,
  output logic                       in_halt,
  output logic                       in_stop,
  output logic                       wt_run,
  output logic                       tmr8_run,
  output logic                       tmr16_run,
  output logic                       adc_run,
  output logic                       clkout_run,
  output logic                       buzzer_run,
  output logic                       serial_run
);
  import swc_pkg::*;

  function automatic logic addr_hit(logic [15:0] a, logic [15:0] target);
    return a == target;
  endfunction

  function automatic swc_count_type settle_limit(logic [2:0] code);
    swc_count_type r;
    r = 18'(WAIT_C4);
    case (code)
      `SWC_SEL_C0: r = 18'(WAIT_C0);
      `SWC_SEL_C1: r = 18'(WAIT_C1);
      `SWC_SEL_C2: r = 18'(WAIT_C2);
      `SWC_SEL_C3: r = 18'(WAIT_C3);
      default:     r = 18'(WAIT_C4);
    endcase
    return r;
  endfunction

  swc_state_type state;
  swc_state_type next_state;
  logic [2:0]    settle_sel;
  logic          wake_req;
  logic          settle_done;
  logic          timer_active;
  logic          stop_ok;
  logic          next_wt;
  logic          next_tmr8;
  logic          next_tmr16;
  logic          next_adc;
  logic          next_clkout;
  logic          next_buzzer;
  logic          next_serial;

  swc_reg_if req_bus();
  swc_reg_if mask_bus();

  // Both flag registers share the CPU write path; only the decode differs.
  assign req_bus.wr_byte  = cpu_wr_byte && addr_hit(cpu_addr, `SWC_ADDR_REQ_H);
  assign req_bus.wr_bit   = cpu_wr_bit && addr_hit(cpu_addr, `SWC_ADDR_REQ_H);
  assign req_bus.bit_sel  = cpu_bit_sel;
  assign req_bus.bit_val  = cpu_bit_val;
  assign req_bus.wdata    = cpu_wdata;
  assign mask_bus.wr_byte = cpu_wr_byte && addr_hit(cpu_addr, `SWC_ADDR_MASK_H);
  assign mask_bus.wr_bit  = cpu_wr_bit && addr_hit(cpu_addr, `SWC_ADDR_MASK_H);
  assign mask_bus.bit_sel = cpu_bit_sel;
  assign mask_bus.bit_val = cpu_bit_val;
  assign mask_bus.wdata   = cpu_wdata;

  swc_flag_reg
  #(
    .RESET_VAL (`SWC_REQ_RESET),
    .SET_BIT   (`SWC_WT_BIT)
  )
  u_req
  (
    .clk    (clk),
    .nrst   (nrst),
    .bus    (req_bus.store),
    .hw_set (watch_overflow)
  );

  swc_flag_reg
  #(
    .RESET_VAL (`SWC_MASK_RESET),
    .SET_BIT   (`SWC_WT_BIT)
  )
  u_mask
  (
    .clk    (clk),
    .nrst   (nrst),
    .bus    (mask_bus.store),
    .hw_set (1'b0)
  );

  // Prohibited codes are dropped so the timer never sees an undefined wait.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      settle_sel <= `SWC_SETTLE_RESET;
    else if (cpu_wr_byte && addr_hit(cpu_addr, `SWC_ADDR_SETTLE)
             && cpu_wdata[2:0] <= `SWC_SETTLE_MAX && cpu_wdata[7:3] == `SWC_SEL_PAD)
      settle_sel <= cpu_wdata[2:0];
  end

  // A flag already pending and unmasked releases sleep at once.
  assign wake_req = req_bus.value[`SWC_WT_BIT] && !mask_bus.value[`SWC_WT_BIT];

  assign timer_active = (state == ST_RSTWAIT) || (state == ST_SETTLE);

  swc_settle_timer u_timer
  (
    .clk       (clk),
    .nrst      (nrst),
    .active    (timer_active),
    .osc_ready (main_osc_ready),
    .limit     (settle_limit(settle_sel)),
    .done      (settle_done)
  );

  assign stop_ok = stop_cmd && !cpu_on_subclk;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RSTWAIT:
        if (settle_done)
          next_state = ST_RUN;
      ST_RUN:
        if (stop_ok)
          next_state = ST_STOP;
        else if (halt_cmd)
          next_state = ST_HALT;
      ST_HALT:
        if (wake_req)
          next_state = ST_RUN;
      ST_STOP:
        if (wake_req)
          next_state = ST_SETTLE;
      ST_SETTLE:
        if (settle_done)
          next_state = ST_RUN;
      default:
        next_state = ST_RSTWAIT;
    endcase
  end

  // Only the sequencer state moves on entry; stored registers keep their contents.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= ST_RSTWAIT;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_clk_en  <= 1'b0;
      main_osc_en <= 1'b0;
      reset_hold  <= 1'b1;
      in_halt     <= 1'b0;
      in_stop     <= 1'b0;
    end
    else
    begin
      cpu_clk_en  <= (next_state == ST_RUN);
      main_osc_en <= (next_state != ST_STOP);
      reset_hold  <= (next_state == ST_RSTWAIT);
      in_halt     <= (next_state == ST_HALT);
      in_stop     <= (next_state == ST_STOP) || (next_state == ST_SETTLE);
    end
  end

  // Resume is a plain restart at the next instruction; no vector is fetched.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resume_next <= 1'b0;
    else
      resume_next <= (state == ST_HALT || state == ST_SETTLE) && next_state == ST_RUN;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      watch_test_signal <= 1'b0;
    else
      watch_test_signal <= watch_overflow;
  end

  always_comb
  begin
    next_wt     = 1'b1;
    next_tmr8   = 1'b1;
    next_tmr16  = 1'b1;
    next_adc    = 1'b1;
    next_clkout = 1'b1;
    next_buzzer = 1'b1;
    next_serial = 1'b1;
    case (state)
      ST_HALT:
        if (cpu_on_subclk && main_osc_halted)
        begin
          next_wt     = wt_src_sub;
          next_tmr8   = tmr8_ext_sel;
          next_tmr16  = 1'b0;
          next_adc    = 1'b0;
          next_clkout = clkout_sub_sel;
          next_buzzer = 1'b0;
          next_serial = serial_ext_sel;
        end
        else if (!cpu_on_subclk && !sub_osc_present)
          next_wt = wt_src_main_div;
      ST_STOP, ST_SETTLE, ST_RSTWAIT:
      begin
        next_wt     = sub_osc_present && wt_src_sub;
        next_tmr8   = tmr8_ext_sel;
        next_tmr16  = 1'b0;
        next_adc    = 1'b0;
        next_clkout = sub_osc_present && clkout_sub_sel;
        next_buzzer = 1'b0;
        next_serial = serial_ext_sel;
      end
      default:
        next_wt = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wt_run     <= 1'b0;
      tmr8_run   <= 1'b0;
      tmr16_run  <= 1'b0;
      adc_run    <= 1'b0;
      clkout_run <= 1'b0;
      buzzer_run <= 1'b0;
      serial_run <= 1'b0;
    end
    else
    begin
      wt_run     <= next_wt;
      tmr8_run   <= next_tmr8;
      tmr16_run  <= next_tmr16;
      adc_run    <= next_adc;
      clkout_run <= next_clkout;
      buzzer_run <= next_buzzer;
      serial_run <= next_serial;
    end
  end

  // Unmapped addresses read as zero so a stray poll never looks like a flag.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cpu_rdata <= `SWC_BYTE_ZERO;
    else if (cpu_rd)
    begin
      if (addr_hit(cpu_addr, `SWC_ADDR_REQ_H))
        cpu_rdata <= req_bus.value;
      else if (addr_hit(cpu_addr, `SWC_ADDR_MASK_H))
        cpu_rdata <= mask_bus.value;
      else if (addr_hit(cpu_addr, `SWC_ADDR_SETTLE))
        cpu_rdata <= {`SWC_SEL_PAD, settle_sel};
      else
        cpu_rdata <= `SWC_BYTE_ZERO;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_flag_on_overflow: assert property (
    watch_overflow |=> (req_bus.value[`SWC_WT_BIT] && watch_test_signal))
    else $error("watch overflow did not set flag and signal");
  a_mask_holds_halt: assert property (
    (state == ST_HALT && !wake_req) |=> (state == ST_HALT && !cpu_clk_en))
    else $error("masked or absent watch test left halt");
  a_halt_release: assert property (
    (state == ST_HALT && wake_req) |=> (state == ST_RUN && resume_next && cpu_clk_en))
    else $error("unmasked watch test did not release halt");
  a_halt_gating: assert property (
    (state == ST_RUN && halt_cmd && !stop_cmd) |=> (!cpu_clk_en && main_osc_en && in_halt))
    else $error("halt entry gated wrong clocks");
  a_stop_osc_off: assert property (
    (state == ST_RUN && stop_ok) |=> (state == ST_STOP && !main_osc_en && !cpu_clk_en))
    else $error("stop entry left main oscillator running");
  a_stop_on_sub: assert property (
    (state == ST_RUN && stop_cmd && cpu_on_subclk) |=> (state != ST_STOP))
    else $error("stop taken while on subsystem clock");
  a_settle_bitwr: assert property (
    (cpu_wr_bit && !cpu_wr_byte && addr_hit(cpu_addr, `SWC_ADDR_SETTLE))
    |=> (settle_sel == $past(settle_sel)))
    else $error("bit write changed settle select");
  a_settle_code: assert property (
    settle_sel <= `SWC_SETTLE_MAX)
    else $error("settle select holds a prohibited code");
  a_settle_gated: assert property (
    (state == ST_SETTLE || state == ST_RSTWAIT) |-> !cpu_clk_en)
    else $error("cpu clock ran during settle wait");
  a_stop_settle: assert property (
    (state == ST_STOP && wake_req) |=> (state == ST_SETTLE && main_osc_en && !resume_next))
    else $error("stop release skipped settle wait");
  a_reset_wait: assert property (
    $fell(reset_hold) |-> ($past(state) == ST_RSTWAIT && cpu_clk_en))
    else $error("reset processing began outside settle wait");
  a_sub_halt_periph: assert property (
    (state == ST_HALT && cpu_on_subclk && main_osc_halted)
    |=> (!tmr16_run && !adc_run && tmr8_run == $past(tmr8_ext_sel)))
    else $error("peripheral enables wrong in subclock halt");
endmodule // swc_standby_ctrl

/* src/swc_map.svh */
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_SETTLE   16'hFFFA
`define SWC_ADDR_REQ_H    16'hFFE1
`define SWC_ADDR_MASK_H   16'hFFE5
`define SWC_REQ_RESET     8'h00
`define SWC_MASK_RESET    8'hFF
`define SWC_SETTLE_RESET  3'h4
`define SWC_SETTLE_MAX    3'h4
`define SWC_WT_BIT        3'h0
`define SWC_SEL_C0        3'h0
`define SWC_SEL_C1        3'h1
`define SWC_SEL_C2        3'h2
`define SWC_SEL_C3        3'h3
`define SWC_WAIT_C0       4096
`define SWC_WAIT_C1       16384
`define SWC_WAIT_C2       32768
`define SWC_WAIT_C3       65536
`define SWC_WAIT_C4       131072
`define SWC_BYTE_ZERO     8'h00
`define SWC_SEL_PAD       5'h00
`define SWC_CNT_ZERO      18'h00000
`define SWC_CNT_ONE       18'h00001
`endif

/* src/swc_pkg.sv */
package swc_pkg;
  typedef logic [7:0]  swc_byte_type;
  typedef logic [17:0] swc_count_type;
  // Gray order along reset wait, run, halt, stop, settle.
  typedef enum logic [2:0]
  {
    ST_RSTWAIT = 3'h0,
    ST_RUN     = 3'h1,
    ST_HALT    = 3'h3,
    ST_STOP    = 3'h2,
    ST_SETTLE  = 3'h6
  } swc_state_type;
endpackage

/* src/swc_reg_if.sv */
`timescale 1ns/10ps
interface swc_reg_if;
  logic                  wr_byte;
  logic                  wr_bit;
  logic [2:0]            bit_sel;
  logic                  bit_val;
  swc_pkg::swc_byte_type wdata;
  swc_pkg::swc_byte_type value;
  modport ctrl
  (
    output wr_byte, wr_bit, bit_sel, bit_val, wdata,
    input  value
  );
  modport store
  (
    input  wr_byte, wr_bit, bit_sel, bit_val, wdata,
    output value
  );
endinterface

/* src/swc_flag_reg.sv */
`timescale 1ns/10ps
`include "swc_map.svh"
module swc_flag_reg
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [2:0] SET_BIT   = 3'h0
)
(
  input  wire logic  clk,
  input  wire logic  nrst,
  swc_reg_if.store   bus,
  input  wire logic  hw_set
);
  import swc_pkg::*;

  function automatic swc_byte_type bit_merge(swc_byte_type old, logic [2:0] sel, logic v);
    swc_byte_type r;
    r      = old;
    r[sel] = v;
    return r;
  endfunction

  swc_byte_type next_value;

  always_comb
  begin
    next_value = bus.value;
    if (bus.wr_byte)
      next_value = bus.wdata;
    else if (bus.wr_bit)
      next_value = bit_merge(bus.value, bus.bit_sel, bus.bit_val);
    // A hardware event in the same cycle as a software clear still lands.
    if (hw_set)
      next_value[SET_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bus.value <= RESET_VAL;
    else
      bus.value <= next_value;
  end
endmodule // swc_flag_reg

/* src/swc_settle_timer.sv */
`timescale 1ns/10ps
`include "swc_map.svh"
module swc_settle_timer
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   active,
  input  wire logic                   osc_ready,
  input  wire swc_pkg::swc_count_type limit,
  output logic                        done
);
  import swc_pkg::*;

  swc_count_type cnt;

  // Cycles before the oscillator reports running are not part of the wait.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= `SWC_CNT_ZERO;
    else if (!active)
      cnt <= `SWC_CNT_ZERO;
    else if (osc_ready)
      cnt <= cnt + `SWC_CNT_ONE;
  end

  assign done = active && osc_ready && (cnt == limit - `SWC_CNT_ONE);

  a_wait_frozen: assert property (
    @(posedge clk) disable iff (!nrst)
    (active && !osc_ready) |=> (cnt == $past(cnt) || !active))
    else $error("settle count moved before oscillator ready");
endmodule // swc_settle_timer

/* tb/swc_cpu_model.sv */
`timescale 1ns/10ps
// CPU core side: each request starts at a falling edge and is held across one rising edge.
module swc_cpu_model
(
  input  wire logic                  clk,
  input  wire swc_pkg::swc_byte_type cpu_rdata,
  output logic [15:0]                cpu_addr,
  output swc_pkg::swc_byte_type      cpu_wdata,
  output logic                       cpu_wr_byte,
  output logic                       cpu_wr_bit,
  output logic [2:0]                 cpu_bit_sel,
  output logic                       cpu_bit_val,
  output logic                       cpu_rd,
  output logic                       halt_cmd,
  output logic                       stop_cmd
);
  import swc_pkg::*;
  initial
  begin
    {cpu_addr, cpu_wdata, cpu_bit_sel, cpu_bit_val} = '0;
    {cpu_wr_byte, cpu_wr_bit, cpu_rd, halt_cmd, stop_cmd} = 5'h00;
  end
  // Kind 0 writes a byte, kind 1 writes bit d[2:0] with value d[3], kind 2 reads.
  task automatic access(input int kind, input logic [15:0] a, input swc_byte_type d,
                        output swc_byte_type q);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bit_sel = d[2:0];
    cpu_bit_val = d[3];
    cpu_wr_byte = (kind == 0);
    cpu_wr_bit = (kind == 1);
    cpu_rd = (kind == 2);
    @(negedge clk);
    q = cpu_rdata;
    {cpu_wr_byte, cpu_wr_bit, cpu_rd} = 3'h0;
    // A released bus must not keep showing the last address or data.
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask
  // Callers issue the sleep request without first quiescing main-clock peripherals or the converter.
  task automatic sleep(input logic deep);
    @(negedge clk);
    halt_cmd = ~deep;
    stop_cmd = deep;
    @(negedge clk);
    halt_cmd = 1'h0;
    stop_cmd = 1'h0;
  endtask
endmodule // swc_cpu_model

/* tb/standby_wake_controller_tb.sv */
`timescale 1ns/10ps
`include "swc_map.svh"
module standby_wake_controller_tb;
  import swc_pkg::*;
  localparam int unsigned WC [5] = '{4, 6, 8, 10, 12};
  localparam int          GAP    = 3;
  // Sub clock select, sub present, main halted: one halt setup per loop pass.
  localparam logic [2:0]  HALT_SETUP [4] = '{3'h0, 3'h2, 3'h7, 3'h6};
  logic         clk, nrst, watch_overflow, cpu_on_subclk, sub_osc_present, main_osc_halted;
  logic         wt_src_main_div, wt_src_sub, tmr8_ext_sel, clkout_sub_sel, serial_ext_sel;
  logic         main_osc_ready = 1'h0;
  logic [15:0]  cpu_addr, a;
  logic [2:0]   cpu_bit_sel;
  swc_byte_type cpu_wdata, cpu_rdata, q, d, d2, sh_set;
  logic         cpu_wr_byte, cpu_wr_bit, cpu_bit_val, cpu_rd, halt_cmd, stop_cmd;
  logic         cpu_clk_en, main_osc_en, resume_next, reset_hold, watch_test_signal;
  logic         in_halt, in_stop, wt_run, tmr8_run, tmr16_run, adc_run;
  logic         clkout_run, buzzer_run, serial_run;
  int           err_count, n_tests, n;
  int           osc_cnt = 0;

  swc_cpu_model u_cpu
  (
    .clk(clk), .cpu_rdata(cpu_rdata), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr_byte(cpu_wr_byte), .cpu_wr_bit(cpu_wr_bit), .cpu_bit_sel(cpu_bit_sel),
    .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .halt_cmd(halt_cmd), .stop_cmd(stop_cmd)
  );
  swc_standby_ctrl
  #(.WAIT_C0(WC[0]), .WAIT_C1(WC[1]), .WAIT_C2(WC[2]), .WAIT_C3(WC[3]), .WAIT_C4(WC[4]))
  u_dut
  (
    .clk(clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr_byte(cpu_wr_byte), .cpu_wr_bit(cpu_wr_bit), .cpu_bit_sel(cpu_bit_sel),
    .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .halt_cmd(halt_cmd), .stop_cmd(stop_cmd),
    .cpu_on_subclk(cpu_on_subclk), .sub_osc_present(sub_osc_present),
    .main_osc_halted(main_osc_halted), .main_osc_ready(main_osc_ready),
    .watch_overflow(watch_overflow), .wt_src_main_div(wt_src_main_div),
    .wt_src_sub(wt_src_sub), .tmr8_ext_sel(tmr8_ext_sel), .clkout_sub_sel(clkout_sub_sel),
    .serial_ext_sel(serial_ext_sel), .cpu_rdata(cpu_rdata), .cpu_clk_en(cpu_clk_en),
    .main_osc_en(main_osc_en), .resume_next(resume_next), .reset_hold(reset_hold),
    .watch_test_signal(watch_test_signal), .in_halt(in_halt), .in_stop(in_stop),
    .wt_run(wt_run), .tmr8_run(tmr8_run), .tmr16_run(tmr16_run), .adc_run(adc_run),
    .clkout_run(clkout_run), .buzzer_run(buzzer_run), .serial_run(serial_run)
  );

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // The oscillator needs a few cycles after enable before it may be counted.
  always @(negedge clk)
  begin
    if (main_osc_en !== 1'h1)
    begin
      osc_cnt <= 0;
      main_osc_ready <= 1'h0;
    end
    else if (osc_cnt < GAP)
      osc_cnt <= osc_cnt + 1;
    else
      main_osc_ready <= 1'h1;
  end

  function automatic swc_byte_type bit_wr(swc_byte_type v, swc_byte_type b);
    bit_wr = v;
    bit_wr[b[2:0]] = b[3];
  endfunction

  function automatic swc_byte_type settle_next(swc_byte_type cur, swc_byte_type b);
    return (b <= 8'h04) ? b : cur;
  endfunction

  function automatic logic [6:0] periph_exp(int m);
    if (m == 1 || m == 3)
      return 7'h7F;
    return {wt_src_sub, tmr8_ext_sel, 2'h0, clkout_sub_sel, 1'h0, serial_ext_sel};
  endfunction

  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic rd_chk(input string what, input logic [15:0] ad, input swc_byte_type exp);
    u_cpu.access(2, ad, 8'h00, q);
    check(what, exp, q);
  endtask

  task automatic wait_run;
    n = 0;
    while (cpu_clk_en !== 1'h1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    check("cpu clock return", 18'h1, n < 3000);
  endtask

  task automatic ovf;
    @(negedge clk);
    watch_overflow = 1'h1;
    @(negedge clk);
    watch_overflow = 1'h0;
    check("watch_test_signal", 18'h1, watch_test_signal);
  endtask

  task automatic do_reset;
    nrst = 1'h0;
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    wait_run;
    check("reset wait", 18'h1, n >= WC[4] + GAP && n <= WC[4] + GAP + 4);
    check("reset_hold", 18'h0, reset_hold);
    sh_set = 8'h04;
    rd_chk("request reg", `SWC_ADDR_REQ_H, 8'h00);
    rd_chk("mask reg", `SWC_ADDR_MASK_H, 8'hFF);
    rd_chk("settle reg", `SWC_ADDR_SETTLE, 8'h04);
    rd_chk("unmapped read", 16'hFFF0, 8'h00);
    $display("test reset done, wait %0d", n);
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    check("run time", 18'h0, 18'h1);
    finish_test;
  end

  initial
  begin
    {nrst, watch_overflow, cpu_on_subclk, main_osc_halted} = 4'h0;
    sub_osc_present = 1'h1;
    {wt_src_main_div, wt_src_sub, tmr8_ext_sel, clkout_sub_sel, serial_ext_sel} = 5'h1F;
    err_count = 0;
    n_tests = 0;
    void'($urandom(67234));
    do_reset;
    for (int i = 0; i < 8; i++)
    begin
      a = i[0] ? `SWC_ADDR_MASK_H : `SWC_ADDR_REQ_H;
      d = 8'($urandom);
      d2 = 8'($urandom);
      u_cpu.access(0, a, d, q);
      u_cpu.access(1, a, d2, q);
      rd_chk("flag reg", a, bit_wr(d, d2));
    end
    for (int i = 0; i < 12; i++)
    begin
      d = (i < 8) ? 8'(i) : 8'($urandom);
      u_cpu.access(0, `SWC_ADDR_SETTLE, d, q);
      sh_set = settle_next(sh_set, d);
      rd_chk("settle select", `SWC_ADDR_SETTLE, sh_set);
    end
    u_cpu.access(1, `SWC_ADDR_SETTLE, 8'h0A, q);
    rd_chk("settle bit write", `SWC_ADDR_SETTLE, sh_set);
    $display("test registers done");
    u_cpu.access(0, `SWC_ADDR_REQ_H, 8'h00, q);
    u_cpu.access(0, `SWC_ADDR_MASK_H, 8'hFF, q);
    ovf;
    rd_chk("masked flag", `SWC_ADDR_REQ_H, 8'h01);
    u_cpu.sleep(1'h0);
    repeat (20) @(negedge clk);
    check("masked halt", 18'h1, {in_halt, cpu_clk_en, resume_next} == 3'h4);
    do_reset;
    u_cpu.access(1, `SWC_ADDR_MASK_H, 8'h00, q);
    for (int m = 0; m < 4; m++)
    begin
      {cpu_on_subclk, sub_osc_present, main_osc_halted} = HALT_SETUP[m];
      {wt_src_main_div, wt_src_sub, tmr8_ext_sel, clkout_sub_sel, serial_ext_sel} = 5'($urandom);
      u_cpu.sleep(1'h0);
      repeat (2) @(negedge clk);
      check("halt clock gate", 18'h0, cpu_clk_en);
      if (m == 0)
        check("watch run", wt_src_main_div, wt_run);
      else
        check("enables", periph_exp(m), {wt_run, tmr8_run, tmr16_run, adc_run, clkout_run,
              buzzer_run, serial_run});
      repeat ($urandom_range(1, 8)) @(negedge clk);
      ovf;
      wait_run;
      check("halt resume", 18'h1, {resume_next, in_halt} == 2'h2);
      rd_chk("mask held", `SWC_ADDR_MASK_H, 8'hFE);
      rd_chk("flag polled", `SWC_ADDR_REQ_H, 8'h01);
      u_cpu.access(1, `SWC_ADDR_REQ_H, 8'h00, q);
      $display("test halt setup %0d done", m);
    end
    {cpu_on_subclk, main_osc_halted} = 2'h0;
    for (int c = 0; c < 5; c++)
    begin
      u_cpu.access(0, `SWC_ADDR_SETTLE, 8'(c), q);
      u_cpu.sleep(1'h1);
      check("stop entry", 18'h1, {main_osc_en, in_stop, cpu_clk_en} == 3'h2);
      repeat ($urandom_range(1, 8)) @(negedge clk);
      check("stop enables", periph_exp(2),
            {wt_run, tmr8_run, tmr16_run, adc_run, clkout_run, buzzer_run, serial_run});
      ovf;
      wait_run;
      check("stop wait", 18'h1, n >= WC[c] + GAP && n <= WC[c] + GAP + 4);
      check("stop resume", 18'h1, {resume_next, in_stop} == 2'h2);
      rd_chk("settle held", `SWC_ADDR_SETTLE, 8'(c));
      u_cpu.access(1, `SWC_ADDR_REQ_H, 8'h00, q);
      $display("test stop code %0d done, wait %0d", c, n);
    end
    cpu_on_subclk = 1'h1;
    u_cpu.sleep(1'h1);
    @(negedge clk);
    check("stop on subclock", 18'h3, {in_stop, cpu_clk_en, main_osc_en});
    $display("test stop refusal done");
    finish_test;
  end
endmodule // standby_wake_controller_tb
